// [core/csso_core.sv]
// Sequencer executing set-carry, shift right, subtract, mask test and stop
//
// How it works
// - Set-carry forces carry, other flags kept
// - Shift right keeps bit seven, copies down
// - Shift flags: carry old bit zero, V cleared
// - Stop halts CPU and system clocks
// - Stop mode keeps all register contents
// - External reset or interrupt ends stop
// - Subtract adds source complement, writes destination
// - Subtract flags: borrow, zero, sign, overflow
// - Subtract sets D, H flags low-nibble borrow
// - Mask test inverts destination, writes nothing
// - Mask test flags: Z, S, V cleared
`timescale 1ns/1ps
module csso_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Instruction byte stream
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    output logic fetch_req_r,
    // Register file port, read data one cycle after read strobe
    output logic [7:0] rf_addr_r,
    output logic rf_rd_r,
    output logic rf_we_r,
    output logic [7:0] rf_wdata_r,
    input wire logic [7:0] rf_rdata,
    // Flags and retirement
    output logic [5:0] flags_r,
    output logic done_r,
    output logic illegal_r,
    output logic [1:0] instr_bytes_r,
    output logic [2:0] instr_cycles_r,
    // Power-down
    input wire logic ext_int,
    output logic stop_mode_r,
    output logic cpu_clk_en_r,
    output logic sys_clk_en_r
);
    import csso_pkg::*;

    csso_state_t state_r;
    csso_state_t state_nxt;
    logic [7:0] opc_r;
    logic [7:0] src_addr_r;
    logic [7:0] dst_addr_r;
    logic [7:0] src_val_r;
    logic src_mem_r;
    logic ind_dst_r;
    logic ext_int_meta_r;
    logic ext_int_sync_r;
    logic take;
    logic is_shr;
    logic [3:0] mode;
    logic [3:0] grp;
    csso_alu_op_t alu_op;
    logic [7:0] alu_result;
    logic [5:0] alu_flags;
    logic alu_wr;

    assign take = fetch_req_r & fetch_valid;
    assign mode = opc_r[3:0];
    assign grp = opc_r[7:4];
    assign is_shr = (opc_r == OPC_SHR_R) || (opc_r == OPC_SHR_IR);

    always_comb begin
        if (opc_r == OPC_SET_CARRY) begin
            alu_op = ALU_SET_C;
        end else if (is_shr) begin
            alu_op = ALU_SHR;
        end else if (grp == GRP_SUB) begin
            alu_op = ALU_SUB;
        end else begin
            alu_op = ALU_MASK;
        end
    end

    csso_alu u_alu (
        .op(alu_op),
        .dst(rf_rdata),
        .src(src_val_r),
        .flags_in(flags_r),
        .result(alu_result),
        .flags_out(alu_flags),
        .wr_dst(alu_wr)
    );

    // Interrupt pin synchroniser
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_int_meta_r <= 1'b0;
            ext_int_sync_r <= 1'b0;
        end else begin
            ext_int_meta_r <= ext_int;
            ext_int_sync_r <= ext_int_meta_r;
        end
    end

    function automatic logic legal_two_op(input logic [7:0] b);
        legal_two_op = (b[7:4] == GRP_SUB || b[7:4] == GRP_MASK) && b[3:0] >= MODE_WR_WR && b[3:0] <= MODE_R_IM;
    endfunction

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_FETCH: begin
                if (take) begin
                    if (fetch_byte == OPC_SET_CARRY) begin
                        state_nxt = S_EXEC;
                    end else if (fetch_byte == OPC_STOP) begin
                        state_nxt = S_STOP;
                    end else if (fetch_byte == OPC_SHR_R || fetch_byte == OPC_SHR_IR || legal_two_op(fetch_byte)) begin
                        state_nxt = S_OPND1;
                    end
                end
            end
            S_OPND1: begin
                if (take) begin
                    if (opc_r == OPC_SHR_R || mode == MODE_WR_WR && !is_shr) begin
                        state_nxt = (opc_r == OPC_SHR_R) ? S_RDDST : S_RDSRC;
                    end else if (opc_r == OPC_SHR_IR || mode == MODE_WR_IWR) begin
                        state_nxt = S_RDPTR;
                    end else begin
                        state_nxt = S_OPND2;
                    end
                end
            end
            S_OPND2: begin
                if (take) begin
                    unique case (mode)
                        MODE_R_R: state_nxt = S_RDSRC;
                        MODE_R_IR: state_nxt = S_RDPTR;
                        default: state_nxt = S_RDDST;
                    endcase
                end
            end
            S_RDPTR: state_nxt = S_PTRWT;
            S_PTRWT: state_nxt = S_GETPTR;
            S_GETPTR: state_nxt = ind_dst_r ? S_RDDST : S_RDSRC;
            S_RDSRC: state_nxt = S_RDDST;
            S_RDDST: state_nxt = S_CAPS;
            S_CAPS: state_nxt = S_EXEC;
            S_EXEC: state_nxt = S_FETCH;
            S_STOP: begin
                if (ext_int_sync_r) begin
                    state_nxt = S_FETCH;
                end
            end
            default: state_nxt = S_FETCH;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= S_FETCH;
            fetch_req_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fetch_req_r <= (state_nxt == S_FETCH) || (state_nxt == S_OPND1) || (state_nxt == S_OPND2);
        end
    end

    // Opcode and operand capture
    always_ff @(posedge core_clk) begin
        if (rst) begin
            opc_r <= 8'h00;
            src_addr_r <= 8'h00;
            dst_addr_r <= 8'h00;
            src_val_r <= 8'h00;
            src_mem_r <= 1'b0;
            ind_dst_r <= 1'b0;
        end else if (take && state_r == S_FETCH) begin
            opc_r <= fetch_byte;
            src_mem_r <= 1'b1;
            ind_dst_r <= (fetch_byte == OPC_SHR_IR);
        end else if (take && state_r == S_OPND1) begin
            if (is_shr) begin
                dst_addr_r <= fetch_byte;
                src_mem_r <= 1'b0;
            end else if (mode == MODE_WR_WR || mode == MODE_WR_IWR) begin
                dst_addr_r <= {WREG_PAGE, fetch_byte[7:4]};
                src_addr_r <= {WREG_PAGE, fetch_byte[3:0]};
            end else if (mode == MODE_R_IM) begin
                dst_addr_r <= fetch_byte;
            end else begin
                src_addr_r <= fetch_byte;
            end
        end else if (take && state_r == S_OPND2) begin
            if (mode == MODE_R_IM) begin
                src_val_r <= fetch_byte;
                src_mem_r <= 1'b0;
            end else begin
                dst_addr_r <= fetch_byte;
            end
        end else if (state_r == S_GETPTR) begin
            if (ind_dst_r) begin
                dst_addr_r <= rf_rdata;
            end else begin
                src_addr_r <= rf_rdata;
            end
        end else if (state_r == S_CAPS && src_mem_r) begin
            src_val_r <= rf_rdata;
        end
    end

    // Register file strobes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rf_addr_r <= 8'h00;
            rf_rd_r <= 1'b0;
            rf_we_r <= 1'b0;
            rf_wdata_r <= 8'h00;
        end else begin
            rf_rd_r <= 1'b0;
            rf_we_r <= 1'b0;
            unique case (state_r)
                S_RDPTR: begin
                    rf_addr_r <= ind_dst_r ? dst_addr_r : src_addr_r;
                    rf_rd_r <= 1'b1;
                end
                S_RDSRC: begin
                    rf_addr_r <= src_addr_r;
                    rf_rd_r <= 1'b1;
                end
                S_RDDST: begin
                    rf_addr_r <= dst_addr_r;
                    rf_rd_r <= 1'b1;
                end
                S_EXEC: begin
                    rf_addr_r <= dst_addr_r;
                    rf_we_r <= alu_wr;
                    rf_wdata_r <= alu_result;
                end
                default: ;
            endcase
        end
    end

    // Flags and retirement
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags_r <= FLAGS_RST;
            done_r <= 1'b0;
            illegal_r <= 1'b0;
            instr_bytes_r <= BYTES_1;
            instr_cycles_r <= CYC_4;
        end else begin
            done_r <= (state_r == S_EXEC) || (state_r == S_FETCH && take && fetch_byte == OPC_STOP);
            illegal_r <= (state_r == S_FETCH) && take && (state_nxt == S_FETCH) && fetch_byte != OPC_STOP;
            if (state_r == S_EXEC) begin
                flags_r <= alu_flags;
            end
            if (state_r == S_FETCH && take) begin
                if (fetch_byte == OPC_SET_CARRY || fetch_byte == OPC_STOP) begin
                    instr_bytes_r <= BYTES_1;
                    instr_cycles_r <= CYC_4;
                end else if (fetch_byte == OPC_SHR_R || fetch_byte == OPC_SHR_IR
                    || fetch_byte[3:0] == MODE_WR_WR) begin
                    instr_bytes_r <= BYTES_2;
                    instr_cycles_r <= CYC_4;
                end else begin
                    instr_bytes_r <= (fetch_byte[3:0] == MODE_WR_IWR) ? BYTES_2 : BYTES_3;
                    instr_cycles_r <= CYC_6;
                end
            end
        end
    end

    // Power-down clock gating
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_mode_r <= 1'b0;
            cpu_clk_en_r <= 1'b1;
            sys_clk_en_r <= 1'b1;
        end else begin
            stop_mode_r <= (state_nxt == S_STOP);
            cpu_clk_en_r <= (state_nxt != S_STOP);
            sys_clk_en_r <= (state_nxt != S_STOP);
        end
    end

    // Checking
    logic [7:0] dst_seen_r;
    logic [5:0] flags_prev_r;
    always_ff @(posedge core_clk) begin
        dst_seen_r <= rf_rdata;
        flags_prev_r <= flags_r;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_set_carry;
        (state_r == S_EXEC && alu_op == ALU_SET_C) |=> flags_r[FLAG_C] && flags_r[5:1] == flags_prev_r[5:1];
    endproperty
    a_set_carry: assert property (p_set_carry) else $error("carry not set alone");
    property p_shr_data;
        (state_r == S_EXEC && alu_op == ALU_SHR) |=> rf_we_r && rf_wdata_r == {dst_seen_r[7], dst_seen_r[7:1]};
    endproperty
    a_shr_data: assert property (p_shr_data) else $error("shift result wrong");
    property p_shr_flags;
        (state_r == S_EXEC && alu_op == ALU_SHR) |=> flags_r[FLAG_C] == dst_seen_r[0] && !flags_r[FLAG_V]
            && flags_r[FLAG_Z] == (rf_wdata_r == 8'h00) && flags_r[5:4] == flags_prev_r[5:4];
    endproperty
    a_shr_flags: assert property (p_shr_flags) else $error("shift flags wrong");
    property p_stop;
        (state_r == S_FETCH && take && fetch_byte == OPC_STOP) |=> stop_mode_r && !cpu_clk_en_r && !sys_clk_en_r
            && flags_r == flags_prev_r;
    endproperty
    a_stop: assert property (p_stop) else $error("stop entry wrong");
    property p_stop_hold;
        stop_mode_r |-> !rf_we_r && $stable(flags_r);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("state changed in stop");
    property p_wake;
        (stop_mode_r && state_r == S_STOP && ext_int_sync_r) |=> !stop_mode_r && cpu_clk_en_r;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on interrupt");
    property p_sub;
        (state_r == S_EXEC && alu_op == ALU_SUB) |=> rf_we_r && rf_wdata_r == 8'(dst_seen_r - src_val_r)
            && flags_r[FLAG_C] == (src_val_r > dst_seen_r);
    endproperty
    a_sub: assert property (p_sub) else $error("subtract wrong");
    property p_sub_d;
        (state_r == S_EXEC && alu_op == ALU_SUB) |=> flags_r[FLAG_D]
            && flags_r[FLAG_H] == (src_val_r[3:0] > dst_seen_r[3:0]);
    endproperty
    a_sub_d: assert property (p_sub_d) else $error("subtract D or H wrong");
    property p_mask_test;
        (state_r == S_EXEC && alu_op == ALU_MASK) |=> !rf_we_r && !flags_r[FLAG_V]
            && flags_r[FLAG_Z] == ((~dst_seen_r & src_val_r) == 8'h00) && flags_r[FLAG_C] == flags_prev_r[FLAG_C];
    endproperty
    a_mask_test: assert property (p_mask_test) else $error("mask test wrong");
    property p_ptr;
        (state_r == S_GETPTR) |=> (ind_dst_r ? dst_addr_r : src_addr_r) == $past(rf_rdata);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not used");

    c_sub: cover property (state_r == S_EXEC && alu_op == ALU_SUB);
    c_ind: cover property (state_r == S_GETPTR ##3 state_r == S_EXEC);
    c_wake: cover property (stop_mode_r ##1 !stop_mode_r);
endmodule

// [pkg/csso_pkg.sv]
// Constants and types for the carry, shift, subtract, mask-test and stop execution block
package csso_pkg;
    // Opcodes
    localparam logic [7:0] OPC_SET_CARRY = 8'hDF;
    localparam logic [7:0] OPC_STOP = 8'h7F;
    localparam logic [7:0] OPC_SHR_R = 8'hD0;
    localparam logic [7:0] OPC_SHR_IR = 8'hD1;
    localparam logic [3:0] GRP_SUB = 4'h2;
    localparam logic [3:0] GRP_MASK = 4'h6;
    // Low nibble of a two-operand opcode selects the addressing form
    localparam logic [3:0] MODE_WR_WR = 4'h2;
    localparam logic [3:0] MODE_WR_IWR = 4'h3;
    localparam logic [3:0] MODE_R_R = 4'h4;
    localparam logic [3:0] MODE_R_IR = 4'h5;
    localparam logic [3:0] MODE_R_IM = 4'h6;
    // Working registers sit in this page of the register file
    localparam logic [3:0] WREG_PAGE = 4'hC;
    // Flag positions in the flags vector
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_S = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_D = 4;
    localparam int FLAG_H = 5;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    // Instruction lengths and cycle counts
    localparam logic [1:0] BYTES_1 = 2'd1;
    localparam logic [1:0] BYTES_2 = 2'd2;
    localparam logic [1:0] BYTES_3 = 2'd3;
    localparam logic [2:0] CYC_4 = 3'd4;
    localparam logic [2:0] CYC_6 = 3'd6;

    typedef enum logic [1:0] {
        ALU_SET_C = 2'b00,
        ALU_SHR = 2'b01,
        ALU_SUB = 2'b10,
        ALU_MASK = 2'b11
    } csso_alu_op_t;

    typedef enum logic [3:0] {
        S_FETCH = 4'b0000,
        S_OPND1 = 4'b0001,
        S_OPND2 = 4'b0010,
        S_RDPTR = 4'b0011,
        S_PTRWT = 4'b0100,
        S_GETPTR = 4'b0101,
        S_RDSRC = 4'b0110,
        S_RDDST = 4'b0111,
        S_CAPS = 4'b1000,
        S_EXEC = 4'b1001,
        S_STOP = 4'b1010
    } csso_state_t;
endpackage

// [core/csso_alu.sv]
// Operand transform and flag update for the four ALU operations (set-carry, shift, subtract, mask test)
`timescale 1ns/1ps
module csso_alu (
    // Operation
    input wire csso_pkg::csso_alu_op_t op,
    // Operands and flags
    input wire logic [7:0] dst,
    input wire logic [7:0] src,
    input wire logic [5:0] flags_in,
    // Results
    output logic [7:0] result,
    output logic [5:0] flags_out,
    output logic wr_dst
);
    import csso_pkg::*;

    logic [8:0] sum;
    logic [4:0] lo_sum;

    // Two's complement add of the source
    assign sum = {1'b0, dst} + {1'b0, ~src} + 9'h001;
    assign lo_sum = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;

    always_comb begin
        result = dst;
        flags_out = flags_in;
        wr_dst = 1'b0;
        unique case (op)
            ALU_SET_C: begin
                flags_out[FLAG_C] = 1'b1;
            end
            ALU_SHR: begin
                result = {dst[7], dst[7:1]};
                wr_dst = 1'b1;
                flags_out[FLAG_C] = dst[0];
                flags_out[FLAG_Z] = (result == 8'h00);
                flags_out[FLAG_S] = result[7];
                flags_out[FLAG_V] = 1'b0;
            end
            ALU_SUB: begin
                result = sum[7:0];
                wr_dst = 1'b1;
                flags_out[FLAG_C] = ~sum[8];
                flags_out[FLAG_Z] = (result == 8'h00);
                flags_out[FLAG_S] = result[7];
                flags_out[FLAG_V] = (dst[7] ^ src[7]) & (result[7] == src[7]);
                flags_out[FLAG_D] = 1'b1;
                flags_out[FLAG_H] = ~lo_sum[4];
            end
            ALU_MASK: begin
                result = ~dst & src;
                flags_out[FLAG_Z] = (result == 8'h00);
                flags_out[FLAG_S] = result[7];
                flags_out[FLAG_V] = 1'b0;
            end
        endcase
    end
endmodule

// [verif/csso_rf_model.sv]
// Register file model standing behind the execution block
`timescale 1ns/1ps
module csso_rf_model (
    // Clock
    input wire logic core_clk,
    // Register file port
    input wire logic [7:0] rf_addr,
    input wire logic rf_rd,
    input wire logic rf_we,
    input wire logic [7:0] rf_wdata,
    output logic [7:0] rf_rdata
);
    logic [7:0] mem [0:255];
    initial rf_rdata = 8'h5A;
    always @(posedge core_clk) begin
        if (rf_we) mem[rf_addr] <= rf_wdata;
    end
    // Data good only the cycle after a strobe, toggles otherwise
    always @(posedge core_clk) begin
        if (rf_rd) rf_rdata <= mem[rf_addr];
        else rf_rdata <= ~rf_rdata;
    end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the carry, shift, subtract, mask-test and stop block
`timescale 1ns/1ps
module tb_top;
    import csso_pkg::*;
    localparam int STAB_CYC = 16;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic fetch_valid = 1'b0;
    logic [7:0] fetch_byte = 8'h00;
    logic ext_int = 1'b0;
    logic fetch_req_r, rf_rd_r, rf_we_r, done_r, illegal_r, stop_mode_r, cpu_clk_en_r, sys_clk_en_r;
    logic [7:0] rf_addr_r, rf_wdata_r, rf_rdata;
    logic [5:0] flags_r, fl;
    logic [1:0] instr_bytes_r;
    logic [2:0] instr_cycles_r;
    logic [7:0] sh [0:255];
    logic [7:0] opl [13] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66,
                              OPC_SHR_R, OPC_SHR_IR, OPC_SET_CARRY};
    logic [10:0] ret_q [$];
    logic [15:0] wr_q [$];
    logic [10:0] re;
    logic [15:0] wn;
    int n_fail = 0;
    int check_count = 0;
    int n_ill = 0;
    int n;

    always #2 core_clk = ~core_clk;

    csso_core dut_u (.core_clk(core_clk), .rst(rst), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
        .fetch_req_r(fetch_req_r), .rf_addr_r(rf_addr_r), .rf_rd_r(rf_rd_r), .rf_we_r(rf_we_r),
        .rf_wdata_r(rf_wdata_r), .rf_rdata(rf_rdata), .flags_r(flags_r), .done_r(done_r),
        .illegal_r(illegal_r), .instr_bytes_r(instr_bytes_r), .instr_cycles_r(instr_cycles_r),
        .ext_int(ext_int), .stop_mode_r(stop_mode_r), .cpu_clk_en_r(cpu_clk_en_r), .sys_clk_en_r(sys_clk_en_r));
    csso_rf_model rf_u (.core_clk(core_clk), .rf_addr(rf_addr_r), .rf_rd(rf_rd_r), .rf_we(rf_we_r),
        .rf_wdata(rf_wdata_r), .rf_rdata(rf_rdata));

    task automatic fail_msg(input logic [15:0] g, input logic [15:0] e);
        n_fail++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic chk_flags(input logic [5:0] g, input logic [5:0] e);
        check_count++;
        if (g !== e) fail_msg({10'h000, g}, {10'h000, e});
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) fail_msg({8'h00, g}, {8'h00, e});
    endtask
    task automatic chk_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) fail_msg({15'h0000, g}, {15'h0000, e});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Retirement and write monitor
    always @(posedge core_clk) begin
        if (rst === 1'b0 && done_r === 1'b1) begin
            if (ret_q.size() == 0) fail_msg(16'h0000, 16'hFFFF);
            else begin
                re = ret_q.pop_front();
                chk_flags(flags_r, re[10:5]);
                chk_byte({6'h00, instr_bytes_r}, {6'h00, re[4:3]});
                chk_byte({5'h00, instr_cycles_r}, {5'h00, re[2:0]});
            end
        end
        if (rst === 1'b0 && rf_we_r === 1'b1) begin
            if (wr_q.size() == 0) fail_msg({rf_addr_r, rf_wdata_r}, 16'h0000);
            else begin
                wn = wr_q.pop_front();
                chk_byte(rf_addr_r, wn[15:8]);
                chk_byte(rf_wdata_r, wn[7:0]);
            end
        end
        if (stop_mode_r === 1'b1) chk_bit(rf_we_r | rf_rd_r | cpu_clk_en_r | sys_clk_en_r, 1'b0);
        if (illegal_r === 1'b1) n_ill++;
    end

    task automatic send_byte(input logic [7:0] b);
        int gap;
        int k;
        gap = $urandom % 3;
        if (gap != 0) begin
            fetch_valid <= 1'b0;
            fetch_byte <= ~b;
            repeat (gap) @(posedge core_clk);
        end
        fetch_valid <= 1'b1;
        fetch_byte <= b;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (fetch_req_r !== 1'b1 && k < 100);
        if (k >= 100) fail_msg({8'h00, b}, 16'hFFFF);
    endtask

    task automatic idle_fetch();
        fetch_valid <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic run_op(input logic [7:0] op);
        logic [7:0] b1, b2, da, sa, d, s, r;
        logic [5:0] f;
        logic [1:0] nb;
        logic [2:0] nc;
        logic wr;
        b1 = 8'($urandom);
        b2 = 8'($urandom);
        f = fl;
        nb = BYTES_3;
        nc = CYC_6;
        wr = 1'b0;
        da = b1;
        r = 8'h00;
        if (op == OPC_SET_CARRY || op == OPC_STOP) begin
            nb = BYTES_1;
            nc = CYC_4;
            if (op == OPC_SET_CARRY) f[FLAG_C] = 1'b1;
        end else if (op == OPC_SHR_R || op == OPC_SHR_IR) begin
            nb = BYTES_2;
            nc = CYC_4;
            if (op == OPC_SHR_IR) da = sh[b1];
            d = sh[da];
            r = {d[7], d[7:1]};
            f[FLAG_C] = d[0];
            f[FLAG_V] = 1'b0;
            wr = 1'b1;
        end else begin
            sa = b1;
            if (op[3:0] == MODE_R_IM && b2[7:6] == 2'b00) b2 = sh[b1];
            if (op[3:0] <= MODE_WR_IWR) begin
                da = {WREG_PAGE, b1[7:4]};
                sa = {WREG_PAGE, b1[3:0]};
                nb = BYTES_2;
                if (op[3:0] == MODE_WR_WR) nc = CYC_4;
            end else if (op[3:0] != MODE_R_IM) begin
                da = b2;
            end
            if (op[3:0] == MODE_WR_IWR || op[3:0] == MODE_R_IR) sa = sh[sa];
            d = sh[da];
            s = (op[3:0] == MODE_R_IM) ? b2 : sh[sa];
            if (op[7:4] == GRP_SUB) begin
                r = d - s;
                f[FLAG_C] = d < s;
                f[FLAG_V] = (d[7] != s[7]) && (r[7] == s[7]);
                f[FLAG_D] = 1'b1;
                f[FLAG_H] = d[3:0] < s[3:0];
                wr = 1'b1;
            end else begin
                r = ~d & s;
                f[FLAG_V] = 1'b0;
            end
        end
        if (op != OPC_SET_CARRY && op != OPC_STOP) begin
            f[FLAG_Z] = (r == 8'h00);
            f[FLAG_S] = r[7];
        end
        ret_q.push_back({f, nb, nc});
        if (wr) begin
            wr_q.push_back({da, r});
            sh[da] = r;
        end
        fl = f;
        send_byte(op);
        if (nb != BYTES_1) send_byte(b1);
        if (nb == BYTES_3) send_byte(b2);
    endtask

    task automatic wait_stop(input logic v);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (stop_mode_r !== v && n < 50);
        chk_bit(stop_mode_r, v);
    endtask

    task automatic chk_reset();
        chk_flags(flags_r, FLAGS_RST);
        chk_bit(stop_mode_r, 1'b0);
        chk_bit(cpu_clk_en_r & sys_clk_en_r, 1'b1);
        chk_byte({6'h00, instr_bytes_r}, {6'h00, BYTES_1});
        chk_byte({5'h00, instr_cycles_r}, {5'h00, CYC_4});
    endtask

    initial begin
        #(4 * 40000);
        fail_msg(16'h0000, 16'h0001);
        wrap_up();
    end

    initial begin
        void'($urandom(22678));
        for (int i = 0; i < 256; i++) begin
            sh[i] = 8'($urandom);
            rf_u.mem[i] = sh[i];
        end
        fl = FLAGS_RST;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk_reset();
        $display("test reset done");
        send_byte(8'h27);
        send_byte(8'h61);
        send_byte(8'hD2);
        idle_fetch();
        repeat (10) @(posedge core_clk);
        chk_byte(n_ill[7:0], 8'h03);
        $display("test illegal done");
        for (int k = 0; k < 400; k++) run_op(k < 13 ? opl[k] : opl[$urandom % 13]);
        $display("test ops done");
        run_op(OPC_STOP);
        idle_fetch();
        wait_stop(1'b1);
        repeat (20) @(posedge core_clk);
        ext_int <= 1'b1;
        wait_stop(1'b0);
        chk_bit(n <= 5, 1'b1);
        repeat (3) @(posedge core_clk);
        ext_int <= 1'b0;
        run_op(OPC_SET_CARRY);
        $display("test stop wake by pin done");
        run_op(OPC_STOP);
        idle_fetch();
        wait_stop(1'b1);
        rst <= 1'b1;
        repeat (STAB_CYC) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk_reset();
        fl = FLAGS_RST;
        for (int k = 0; k < 20; k++) run_op(opl[$urandom % 13]);
        idle_fetch();
        n = 0;
        while ((ret_q.size() != 0 || wr_q.size() != 0) && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        chk_bit(n < 200, 1'b1);
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 256; i++) chk_byte(rf_u.mem[i], sh[i]);
        $display("test stop wake by reset done");
        wrap_up();
    end
endmodule
